//--- rtl/actuator_feedback_framer.sv
// Actuator feedback framer: builds the eight-byte transmit PDO and queues it for the CAN controller
`timescale 1ns/100ps

module actuator_feedback_framer
  import feedback_pkg::*;
#(
  parameter int unsigned OVERLOAD_CYC = OVERLOAD_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [6:0]  node_id,
  input  wire logic [15:0] stroke_limit,
  input  wire logic [15:0] position_raw,
  input  wire logic [15:0] phase_current,
  input  wire logic        pwm_active,
  input  wire logic [7:0]  speed_raw,
  input  wire logic        extending,
  input  wire logic        retracting,
  input  wire logic        at_max_speed,
  input  wire logic [15:0] current_limit,
  input  wire logic        motion_enable,
  input  wire logic [7:0]  error_flags_in,
  input  wire logic        tx_request,
  input  wire logic        od_read,
  input  wire logic [15:0] od_index,
  output logic [15:0]      od_rdata,
  output logic             od_valid,
  output logic             od_miss,
  output logic             motion_permit,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output can_frame_t       tx_frame
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_PUSH
  } build_state_t;

  build_state_t   state;
  build_state_t   next_state;
  feedback_snap_t snap;
  can_frame_t     build_frame;
  logic [15:0]    position_count;
  logic [15:0]    current_sample;
  logic [7:0]     speed_count;
  logic [7:0]     motion_byte;
  logic [7:0]     error_byte;
  logic [7:0]     last_motion;
  logic [31:0]    over_count;
  logic           over_limit;
  logic           overload;
  logic           overload_hit;
  logic           tx_pending;
  logic           motion_event;
  logic           fifo_in_valid;
  logic           fifo_in_ready;
  logic           frame_taken;
  logic           frame_trigger;
  logic [15:0]    position_clamped;
  wire logic [7:0][7:0] lane_data;

  // Low byte first packing of a 16-bit field
  function automatic logic [1:0][7:0] pack_u16(input logic [15:0] value);
    logic [1:0][7:0] bytes;
    bytes[0] = value[7:0];
    bytes[1] = value[15:8];
    return bytes;
  endfunction

  // Index map decode for the miss flag; the data mux decodes od_index in a case of its own
  function automatic logic od_mapped(input logic [15:0] index);
    logic hit;
    case (index)
      OD_POSITION,
      OD_CURRENT,
      OD_SPEED,
      OD_MOTION,
      OD_ERROR: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // Byte of one frame lane, low byte of each 16-bit field first
  function automatic logic [7:0] lane_byte(input int unsigned lane, input feedback_snap_t s);
    logic [1:0][7:0] pos_pair;
    logic [1:0][7:0] cur_pair;
    logic [7:0]      value;
    pos_pair = pack_u16(s.position);
    cur_pair = pack_u16(s.current);
    case (lane)
      BYTE_POS_LO: value = pos_pair[0];
      BYTE_POS_HI: value = pos_pair[1];
      BYTE_CUR_LO: value = cur_pair[0];
      BYTE_CUR_HI: value = cur_pair[1];
      BYTE_SPEED:  value = s.speed;
      BYTE_UNUSED: value = RESET_BYTE;
      BYTE_MOTION: value = s.motion;
      BYTE_ERROR:  value = s.errors;
      default:     value = RESET_BYTE;
    endcase
    return value;
  endfunction

  // Readings past the ordered stroke are pinned to it, with no play correction
  always_comb begin
    position_clamped = position_raw;
    if (position_raw > stroke_limit) begin
      position_clamped = stroke_limit;
    end
  end

  // Position is already in 0.1 mm counts
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      position_count <= RESET_WORD;
    end else begin
      position_count <= position_clamped;
    end
  end

  // Supply current would mislead, so only phase current in the pulse's on time is kept
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      current_sample <= RESET_WORD;
    end else if (pwm_active) begin
      current_sample <= phase_current;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      speed_count <= RESET_BYTE;
    end else begin
      speed_count <= speed_raw;
    end
  end

  // Motion flag byte, upper bits tied low
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      motion_byte <= RESET_BYTE;
    end else begin
      motion_byte                     <= RESET_BYTE;
      motion_byte[MOTION_EXTEND_BIT]  <= extending;
      motion_byte[MOTION_RETRACT_BIT] <= retracting;
      motion_byte[MOTION_SAT_BIT]     <= at_max_speed;
    end
  end

  // Overload watch: sample over limit must persist without a break
  assign over_limit   = (current_sample > current_limit);
  assign overload_hit = over_limit && (over_count >= OVERLOAD_CYC - 1);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      over_count <= '0;
    end else if (!over_limit || overload) begin
      over_count <= '0;
    end else if (!overload_hit) begin
      over_count <= over_count + 32'd1;
    end
  end

  // Flag clears only while enable is low; a new overload in that cycle still wins
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      overload <= 1'b0;
    end else if (overload_hit) begin
      overload <= 1'b1;
    end else if (!motion_enable) begin
      overload <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      motion_permit <= 1'b0;
    end else begin
      motion_permit <= motion_enable && !overload && !overload_hit;
    end
  end

  always_comb begin
    error_byte                     = error_flags_in;
    error_byte[ERROR_OVERLOAD_BIT] = overload;
  end

  // A change of motion flags sends a frame without waiting for a request
  assign motion_event = (motion_byte != last_motion);

  // A request and a flag change in one cycle give one frame, not two
  assign frame_trigger = tx_request || motion_event;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      last_motion <= RESET_BYTE;
    end else begin
      last_motion <= motion_byte;
    end
  end

  // Pending request: a new trigger in the cycle of the load is kept
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_pending <= 1'b0;
    end else if (frame_trigger) begin
      tx_pending <= 1'b1;
    end else if (state == ST_LOAD) begin
      tx_pending <= 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (tx_pending) begin
          next_state = ST_LOAD;
        end
      end
      ST_LOAD: begin
        next_state = ST_PUSH;
      end
      ST_PUSH: begin
        if (fifo_in_ready) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Snapshot keeps all fields of one frame from the same instant
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      snap <= '0;
    end else if (state == ST_LOAD) begin
      snap.position <= position_count;
      snap.current  <= current_sample;
      snap.speed    <= speed_count;
      snap.motion   <= motion_byte;
      snap.errors   <= error_byte;
    end
  end

  // Frame assembly, one pass of the loop per byte lane
  for (genvar lane = 0; lane < 8; lane++) begin : g_lane
    assign lane_data[lane] = lane_byte(lane, snap);
  end

  always_comb begin
    build_frame.cob_id = TPDO_COB_BASE + {4'h0, node_id};
    build_frame.dlc    = FRAME_DLC;
    build_frame.data   = lane_data;
  end

  // A full queue holds the builder in push, so requests merge instead of being lost
  assign fifo_in_valid = (state == ST_PUSH);
  assign frame_taken   = fifo_in_valid && fifo_in_ready;

  // Frames wait here while the controller is busy on the bus
  frame_fifo #(
    .WIDTH ($bits(can_frame_t)),
    .DEPTH (FIFO_DEPTH)
  ) frame_fifo_i (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (build_frame),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_frame)
  );

  // Object dictionary read port, answer one cycle after the request
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      od_valid <= 1'b0;
    end else begin
      od_valid <= od_read;
    end
  end

  // Unmapped index answers with the miss pulse
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      od_miss <= 1'b0;
    end else begin
      od_miss <= od_read && !od_mapped(od_index);
    end
  end

  // Data for a mapped index; a miss reads as zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      od_rdata <= RESET_WORD;
    end else if (od_read) begin
      case (od_index)
        OD_POSITION: od_rdata <= position_count;
        OD_CURRENT:  od_rdata <= current_sample;
        OD_SPEED:    od_rdata <= {8'h00, speed_count};
        OD_MOTION:   od_rdata <= {8'h00, motion_byte};
        OD_ERROR:    od_rdata <= {8'h00, error_byte};
        default: begin
          od_rdata <= RESET_WORD;
        end
      endcase
    end
  end

endmodule

//--- rtl/feedback_pkg.sv
// Constants and types shared by the actuator feedback framer and its frame FIFO
package feedback_pkg;

  // Clock and timing
  localparam int unsigned CLOCK_HZ          = 20_000_000;
  localparam int unsigned OVERLOAD_TIME_US  = 15_000;
  localparam int unsigned OVERLOAD_CYCLES   = (CLOCK_HZ / 1_000_000) * OVERLOAD_TIME_US;

  // Transmit PDO identifier base, added to the node identifier
  localparam logic [10:0] TPDO_COB_BASE     = 11'h180;
  localparam logic [3:0]  FRAME_DLC         = 4'h8;

  // Byte positions inside the eight-byte feedback frame
  localparam int unsigned BYTE_POS_LO       = 0;
  localparam int unsigned BYTE_POS_HI       = 1;
  localparam int unsigned BYTE_CUR_LO       = 2;
  localparam int unsigned BYTE_CUR_HI       = 3;
  localparam int unsigned BYTE_SPEED        = 4;
  localparam int unsigned BYTE_UNUSED       = 5;
  localparam int unsigned BYTE_MOTION       = 6;
  localparam int unsigned BYTE_ERROR        = 7;

  // Motion flag and error flag bit positions
  localparam int unsigned MOTION_EXTEND_BIT = 0;
  localparam int unsigned MOTION_RETRACT_BIT = 1;
  localparam int unsigned MOTION_SAT_BIT    = 2;
  localparam int unsigned ERROR_OVERLOAD_BIT = 1;

  // Object dictionary indices reachable over the read port
  localparam logic [15:0] OD_POSITION       = 16'h2200;
  localparam logic [15:0] OD_CURRENT        = 16'h2201;
  localparam logic [15:0] OD_SPEED          = 16'h2202;
  localparam logic [15:0] OD_MOTION         = 16'h2204;
  localparam logic [15:0] OD_ERROR          = 16'h2205;

  // Values after reset
  localparam logic [15:0] RESET_WORD        = 16'h0000;
  localparam logic [7:0]  RESET_BYTE        = 8'h00;

  // Frame FIFO geometry
  localparam int unsigned FIFO_DEPTH        = 32;

  typedef struct packed {
    logic [10:0]     cob_id;
    logic [3:0]      dlc;
    logic [7:0][7:0] data;
  } can_frame_t;

  typedef struct packed {
    logic [15:0] position;
    logic [15:0] current;
    logic [7:0]  speed;
    logic [7:0]  motion;
    logic [7:0]  errors;
  } feedback_snap_t;

endpackage

//--- rtl/frame_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/100ps
module frame_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;
  logic             do_write;
  logic             do_read;

  // Extra pointer bit tells full from empty without a counter
  assign empty    = (wr_ptr == rd_ptr);
  assign full     = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign do_write = in_valid & ~full;
  assign do_read  = out_ready & ~empty;
  assign out_data = mem[rd_ptr[AW-1:0]];

  always_ff @(posedge clock) begin
    if (do_write) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wr_ptr <= '0;
    end else if (do_write) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_ptr <= '0;
    end else if (do_read) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule

//--- sim/afb_monitor.sv
// Port checker for the actuator feedback framer
`timescale 1ns/100ps
module afb_monitor
  import feedback_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [6:0]  node_id,
  input wire logic [15:0] stroke_limit,
  input wire logic [15:0] position_raw,
  input wire logic [7:0]  speed_raw,
  input wire logic        extending,
  input wire logic        retracting,
  input wire logic        at_max_speed,
  input wire logic        motion_enable,
  input wire logic        od_read,
  input wire logic [15:0] od_index,
  input wire logic [15:0] od_rdata,
  input wire logic        od_valid,
  input wire logic        od_miss,
  input wire logic        motion_permit,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire can_frame_t  tx_frame
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_frame_cob_id: assert property (tx_valid |-> tx_frame.cob_id == TPDO_COB_BASE + 11'(node_id))
    else $error("frame identifier wrong");
  a_frame_len: assert property (tx_valid |-> tx_frame.dlc == FRAME_DLC)
    else $error("frame length wrong");
  a_spare_zero: assert property (tx_valid |-> tx_frame.data[5] == 8'h00 && tx_frame.data[6][7:3] == 5'h00)
    else $error("spare bits not zero");
  a_frame_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("frame dropped while stalled");
  a_od_answer: assert property (od_read |=> od_valid)
    else $error("read not answered");
  a_pos_read: assert property (od_read && od_index == OD_POSITION |=> od_rdata ==
    (($past(position_raw, 2) > $past(stroke_limit, 2)) ? $past(stroke_limit, 2) : $past(position_raw, 2)))
    else $error("position read wrong");
  a_speed_read: assert property (od_read && od_index == OD_SPEED |=> od_rdata == {8'h00, $past(speed_raw, 2)})
    else $error("speed read wrong");
  a_flag_read: assert property (od_read && od_index == OD_MOTION |=>
    od_rdata == {13'h0000, $past(at_max_speed, 2), $past(retracting, 2), $past(extending, 2)})
    else $error("motion flags wrong");
  a_miss_zero: assert property (od_read && od_index == 16'h2203 |=> od_miss && od_rdata == 16'h0000)
    else $error("unmapped read wrong");
  a_permit_off: assert property (!motion_enable |=> !motion_permit)
    else $error("motion permitted without enable");

  c_frame_taken: cover property (tx_valid && tx_ready);
  c_stalled: cover property (tx_valid && !tx_ready [*8]);
  c_overload: cover property (motion_enable && !motion_permit);
endmodule

bind actuator_feedback_framer afb_monitor afb_monitor_i (.*);

//--- sim/can_master_model.sv
// Behavioural CAN controller that drains transmit frames
`timescale 1ns/100ps
module can_master_model
  import feedback_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       stall,
  input  wire logic       tx_valid,
  input  wire can_frame_t tx_frame,
  output logic            tx_ready,
  output can_frame_t      got,
  output int unsigned     n_got
);
  initial begin
    tx_ready = 1'b0;
    n_got = 0;
  end
  // Ready moves just after an edge so a stall never cuts a transfer in half
  always @(posedge clock) begin
    if (tx_valid && tx_ready) begin
      got <= tx_frame;
      n_got <= n_got + 1;
    end
    tx_ready <= #1 !stall;
  end
endmodule

//--- sim/tb_actuator_feedback_framer.sv
// Self-checking bench for the actuator feedback framer
`timescale 1ns/100ps
module tb_actuator_feedback_framer;
  import feedback_pkg::*;
  localparam int unsigned OVL = 20;
  logic        clock, sys_rst, pwm_active, extending, retracting, at_max_speed, motion_enable;
  logic        tx_request, od_read, stall, od_valid, od_miss, motion_permit, tx_valid, tx_ready;
  logic [6:0]  node_id;
  logic [15:0] stroke_limit, position_raw, phase_current, current_limit, od_index, od_rdata;
  logic [7:0]  speed_raw, error_flags_in;
  can_frame_t  tx_frame, got;
  int unsigned n_got, n0;
  int          err_count, n_tests;

  actuator_feedback_framer #(.OVERLOAD_CYC(OVL)) actuator_feedback_framer_i (.clock(clock),
    .sys_rst(sys_rst), .node_id(node_id), .stroke_limit(stroke_limit), .position_raw(position_raw),
    .phase_current(phase_current), .pwm_active(pwm_active), .speed_raw(speed_raw),
    .extending(extending), .retracting(retracting), .at_max_speed(at_max_speed),
    .current_limit(current_limit), .motion_enable(motion_enable), .error_flags_in(error_flags_in),
    .tx_request(tx_request), .od_read(od_read), .od_index(od_index), .od_rdata(od_rdata),
    .od_valid(od_valid), .od_miss(od_miss), .motion_permit(motion_permit), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_frame(tx_frame));
  can_master_model can_master_model_i (.clock(clock), .stall(stall), .tx_valid(tx_valid),
    .tx_frame(tx_frame), .tx_ready(tx_ready), .got(got), .n_got(n_got));

  always #25 clock = ~clock;

  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [78:0] exp, input logic [78:0] act);
    n_tests++;
    if (act !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, act);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic od_rd(input logic [15:0] idx, input logic [15:0] exp);
    cyc(1);
    od_read = 1'b1;
    od_index = idx;
    cyc(1);
    od_read = 1'b0;
    chk("od_valid", 79'(1), 79'(od_valid));
    chk("od_rdata", 79'(exp), 79'(od_rdata));
    chk("od_miss", 79'(idx == 16'h2203), 79'(od_miss));
  endtask

  // Waits a bounded time for the controller to take one more frame
  task automatic frame(input logic [78:0] exp);
    n0 = n_got;
    tx_request = 1'b1;
    cyc(1);
    tx_request = 1'b0;
    for (int i = 0; i < 20 && n_got == n0; i++) cyc(1);
    chk("tx_frame", exp, 79'(got));
  endtask

  initial begin
    repeat (3000) @(posedge clock);
    err_count++;
    give_verdict();
  end

  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    {tx_request, od_read, stall, retracting, at_max_speed} = 5'h00;
    {pwm_active, extending, motion_enable} = 3'h7;
    node_id = 7'h05;
    od_index = 16'h0000;
    stroke_limit = 16'h03E8;
    position_raw = 16'h0400;
    phase_current = 16'h0064;
    current_limit = 16'hFFFF;
    speed_raw = 8'h1E;
    error_flags_in = 8'hA7;
    cyc(4);
    sys_rst = 1'b0;
    cyc(10);
    frame({11'h185, 4'h8, 64'hA501_001E_0064_03E8});
    od_rd(OD_POSITION, 16'h03E8);
    position_raw = 16'h0123;
    pwm_active = 1'b0;
    phase_current = 16'h0FFF;
    cyc(2);
    od_rd(OD_POSITION, 16'h0123);
    od_rd(OD_CURRENT, 16'h0064);
    pwm_active = 1'b1;
    cyc(2);
    od_rd(OD_CURRENT, 16'h0FFF);
    od_rd(OD_SPEED, 16'h001E);
    od_rd(16'h2203, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      {at_max_speed, retracting, extending} = 3'(1 << i);
      cyc(2);
      od_rd(OD_MOTION, {13'h0000, 3'(1 << i)});
      frame({11'h185, 4'h8, 8'hA5, 5'h00, 3'(1 << i), 48'h001E_0FFF_0123});
    end
    // Current stays above the new limit until the overload trips
    current_limit = 16'h0050;
    cyc(OVL - 4);
    chk("motion_permit", 79'(1), 79'(motion_permit));
    cyc(8);
    chk("motion_permit", 79'(0), 79'(motion_permit));
    od_rd(OD_ERROR, 16'h00A7);
    current_limit = 16'hFFFF;
    motion_enable = 1'b0;
    cyc(2);
    motion_enable = 1'b1;
    cyc(2);
    chk("motion_permit", 79'(1), 79'(motion_permit));
    od_rd(OD_ERROR, 16'h00A5);
    // Fill the queue while the controller stalls: 32 stored, one held, one pending
    stall = 1'b1;
    cyc(2);
    for (int i = 0; i < 40; i++) begin
      tx_request = 1'b1;
      cyc(1);
      tx_request = 1'b0;
      cyc(3);
    end
    chk("tx_valid", 79'(1), 79'(tx_valid));
    n0 = n_got;
    stall = 1'b0;
    cyc(150);
    chk("frames_drained", 79'(34), 79'(n_got - n0));
    chk("tx_valid", 79'(0), 79'(tx_valid));
    give_verdict();
  end
endmodule
